// >>> tag_lookup_query_regs.sv
// Tag query register bank: host-set X/Y point, looked-up tag result, APB access.
`default_nettype none

module tag_lookup_query_regs
    import tag_query_pkg::*;
(
    input wire logic clk, // System clock, 10 MHz.
    input wire logic arst_n, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [31:0] paddr, // APB byte address.
    input wire logic [tag_query_pkg::DATA_W-1:0] pwdata, // APB write data.
    input wire logic [3:0] pstrb, // APB byte strobes.
    output logic pready, // APB ready.
    output logic [tag_query_pkg::DATA_W-1:0] prdata, // APB read data.
    output logic pslverr, // APB error for unmapped addresses.
    input wire logic frame_done, // A new frame finished rendering, pulse.
    input wire logic tag_ack, // Tag store answer, pulse.
    input wire logic [tag_query_pkg::TAG_W-1:0] tag_data, // Tag value with tag_ack.
    output logic tag_req, // Tag store request level.
    output logic [tag_query_pkg::COORD_W-1:0] tag_req_x, // X of the requested pixel.
    output logic [tag_query_pkg::COORD_W-1:0] tag_req_y // Y of the requested pixel.
);

    // Whole state kept by the bank itself.
    typedef struct packed {
        logic [COORD_W-1:0] query_x;
        logic [COORD_W-1:0] query_y;
        logic [TAG_W-1:0] result;
        logic pending;
    } bank_s;

    bank_s st_reg; // Registered bank state.
    bank_s st_next; // Next bank state.

    reg_sel_e sel; // Register picked by the current address.
    logic wr_en; // A write completes at this edge.
    logic [DATA_W-1:0] rd_word; // Read value of the addressed register.
    logic fetch_idle; // No lookup in flight toward the tag store.
    logic fetch_done; // A lookup just finished.
    logic [TAG_W-1:0] fetch_tag; // Tag of the lookup that finished.
    logic start; // Launch a lookup with the stored point.
    logic coord_write; // The host changes the X or Y query point.
    logic lo_lanes_on; // Byte lanes holding the coordinate field are written.
    logic busy; // A lookup is pending or in flight.

    // Bus timing and decode live in their own module.
    apb_access u_apb_access (
        .clk(clk),
        .arst_n(arst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .rd_word(rd_word),
        .sel(sel),
        .wr_en(wr_en),
        .pready(pready),
        .prdata(prdata),
        .pslverr(pslverr)
    );

    // The coordinate field spans the two low byte lanes; both must be strobed.
    assign lo_lanes_on = pstrb[0] & pstrb[1];

    // A write to either query register with both low byte lanes strobed is a change of point.
    assign coord_write = wr_en & lo_lanes_on & ((sel == SEL_X) | (sel == SEL_Y));

    // A lookup starts whenever one is owed and the handshake is free.
    assign start = st_reg.pending & fetch_idle;

    // Software sees the bank busy until the latest point has been answered.
    assign busy = st_reg.pending | ~fetch_idle;

    // Handshake with the tag store of the rendered frame.
    tag_fetch u_tag_fetch (
        .clk(clk),
        .arst_n(arst_n),
        .start(start),
        .x(st_reg.query_x),
        .y(st_reg.query_y),
        .tag_ack(tag_ack),
        .tag_data(tag_data),
        .idle(fetch_idle),
        .tag_req(tag_req),
        .tag_req_x(tag_req_x),
        .tag_req_y(tag_req_y),
        .done(fetch_done),
        .tag(fetch_tag)
    );

    // Builds the read word; every bit outside a field stays zero.
    always_comb
    begin
        rd_word = '0; // see RULE2
        unique case (sel)
            SEL_X:
            begin
                // Only the 11-bit coordinate is visible.
                rd_word[COORD_MSB:COORD_LSB] = st_reg.query_x; // see RULE8
            end
            SEL_Y:
            begin
                // Only the 11-bit coordinate is visible.
                rd_word[COORD_MSB:COORD_LSB] = st_reg.query_y; // see RULE7
            end
            SEL_RESULT:
            begin
                // The 8-bit tag sits in the low byte, upper bits zero.
                rd_word[TAG_MSB:TAG_LSB] = st_reg.result; // see RULE4
            end
            SEL_STATUS:
            begin
                // Busy shows that the result may still change.
                rd_word[STATUS_BUSY_BIT] = busy;
            end
            SEL_NONE:
            begin
                // Unmapped: nothing is returned and the bus reports an error.
                rd_word = '0;
            end
        endcase
    end

    // Computes the next bank state from bus writes, frames and lookup answers.
    always_comb
    begin
        st_next = st_reg;

        // Stored point: only the coordinate bits are kept from a write.
        if (wr_en && lo_lanes_on && sel == SEL_X)
        begin
            st_next.query_x = coord_of(pwdata); // see RULE8
        end
        if (wr_en && lo_lanes_on && sel == SEL_Y)
        begin
            st_next.query_y = coord_of(pwdata); // see RULE7
        end
        // Writes to the result and status words change nothing.

        // A launched lookup discharges the debt; a new cause in the same
        // cycle wins so that no change of point or frame is lost.
        if (start)
        begin
            st_next.pending = 1'b0;
        end
        if (coord_write || frame_done)
        begin
            // A new point or a fresh frame both call for a new lookup.
            st_next.pending = 1'b1; // see RULE5, see RULE10
        end

        // A finished lookup updates the result unless a newer point or frame
        // is already waiting; that stale answer would belong to old data.
        // Only the host point drives this path; live touch has no input here.
        if (fetch_done && !st_reg.pending && !coord_write && !frame_done)
        begin
            st_next.result = fetch_tag; // see RULE5, see RULE6
        end
    end

    // Registers the bank state; all fields start at zero.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_reg.query_x <= RST_TAG_QUERY_X; // see RULE8
            st_reg.query_y <= RST_TAG_QUERY_Y; // see RULE7
            st_reg.result <= RST_TAG_QUERY_RESULT; // see RULE4
            st_reg.pending <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

endmodule

`default_nettype wire

// >>> tag_query_pkg.sv
// Shared constants, types and decode helpers for the tag query register bank.
// Functional notes
// RULE1: Every register is one 32-bit word.
// RULE2: Reserved bits read zero; software writes zero.
// RULE3: Offsets decode relative to register space base.
// RULE4: Result register: 8-bit read-only tag, resets zero.
// RULE5: Result follows the tag at queried X/Y.
// RULE6: Result comes only from host coordinates.
// RULE7: Y query register: 11-bit read-write, resets zero.
// RULE8: X query register: 11-bit read-write, resets zero.
// RULE9: Host writes X and Y, then reads result.
// RULE10: Lookup uses the latest rendered frame's tags.
`default_nettype none

package tag_query_pkg;

    // Bus data width; every register occupies one aligned word.
    localparam int unsigned DATA_W = 32;
    // Width of a query coordinate field.
    localparam int unsigned COORD_W = 11;
    // Width of a tag value.
    localparam int unsigned TAG_W = 8;

    // Bus address of the first byte of the register space.
    localparam logic [31:0] REG_SPACE_BASE = 32'h0000_0000;

    // Byte offsets of the registers inside the register space.
    localparam logic [31:0] OFF_TAG_QUERY_X = 32'h0000_0074;
    localparam logic [31:0] OFF_TAG_QUERY_Y = 32'h0000_0078;
    localparam logic [31:0] OFF_TAG_QUERY_RESULT = 32'h0000_007c;
    localparam logic [31:0] OFF_TAG_QUERY_STATUS = 32'h0000_0080;

    // Reset values of the stored fields.
    localparam logic [COORD_W-1:0] RST_TAG_QUERY_X = 11'h000;
    localparam logic [COORD_W-1:0] RST_TAG_QUERY_Y = 11'h000;
    localparam logic [TAG_W-1:0] RST_TAG_QUERY_RESULT = 8'h00;

    // Field positions inside the register words.
    localparam int unsigned COORD_LSB = 0;
    localparam int unsigned COORD_MSB = 10;
    localparam int unsigned TAG_LSB = 0;
    localparam int unsigned TAG_MSB = 7;
    localparam int unsigned STATUS_BUSY_BIT = 0;

    // Register selected by a bus address.
    typedef enum logic [4:0] {
        SEL_NONE = 5'b00001,
        SEL_X = 5'b00010,
        SEL_Y = 5'b00100,
        SEL_RESULT = 5'b01000,
        SEL_STATUS = 5'b10000
    } reg_sel_e;

    // States of the tag store request handshake.
    typedef enum logic [1:0] {
        FETCH_IDLE = 2'b01,
        FETCH_WAIT = 2'b10
    } fetch_state_e;

    // Maps a bus address to a register, counting from the register space base.
    function automatic reg_sel_e decode_reg(input logic [31:0] addr);
        logic [31:0] offset;
        offset = addr - REG_SPACE_BASE; // see RULE3
        if (offset == OFF_TAG_QUERY_X)
            decode_reg = SEL_X;
        else if (offset == OFF_TAG_QUERY_Y)
            decode_reg = SEL_Y;
        else if (offset == OFF_TAG_QUERY_RESULT)
            decode_reg = SEL_RESULT;
        else if (offset == OFF_TAG_QUERY_STATUS)
            decode_reg = SEL_STATUS;
        else
            decode_reg = SEL_NONE;
    endfunction

    // Takes the coordinate field out of a written word; upper bits are dropped.
    function automatic logic [COORD_W-1:0] coord_of(input logic [DATA_W-1:0] word);
        coord_of = word[COORD_MSB:COORD_LSB];
    endfunction

endpackage

`default_nettype wire

// >>> apb_access.sv
// APB slave timing: one wait state, registered answer, error on unmapped address.
`default_nettype none

module apb_access
    import tag_query_pkg::*;
(
    input wire logic clk, // System clock.
    input wire logic arst_n, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [31:0] paddr, // APB byte address.
    input wire logic [tag_query_pkg::DATA_W-1:0] rd_word, // Read value of the addressed register.
    output tag_query_pkg::reg_sel_e sel, // Register picked by paddr.
    output logic wr_en, // High at the edge where a write completes.
    output logic pready, // APB ready, from a flip-flop.
    output logic [tag_query_pkg::DATA_W-1:0] prdata, // APB read data, from a flip-flop.
    output logic pslverr // APB error, from a flip-flop.
);

    // Whole state of the bus answer.
    typedef struct packed {
        logic pready;
        logic [DATA_W-1:0] prdata;
        logic pslverr;
    } apb_s;

    apb_s st_reg;
    apb_s st_next;
    logic access; // Access phase of a transfer is in progress.

    assign sel = decode_reg(paddr);
    assign access = psel & penable;
    // A write lands only at the edge where the master sees pready high.
    assign wr_en = access & st_reg.pready & pwrite & ~st_reg.pslverr;
    assign pready = st_reg.pready;
    assign prdata = st_reg.prdata;
    assign pslverr = st_reg.pslverr;

    // Raises pready in the second access cycle; answer words stand for that one cycle.
    always_comb
    begin
        st_next = '0;
        if (access && !st_reg.pready)
        begin
            st_next.pready = 1'b1;
            st_next.pslverr = (sel == SEL_NONE);
            // Unmapped reads and all writes return zero.
            st_next.prdata = (!pwrite && sel != SEL_NONE) ? rd_word : '0; // see RULE1
        end
    end

    // Registers the answer state.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

endmodule

`default_nettype wire

// >>> tag_fetch.sv
// Request and acknowledge handshake toward the rendered-frame tag store.
`default_nettype none

module tag_fetch
    import tag_query_pkg::*;
(
    input wire logic clk, // System clock.
    input wire logic arst_n, // Asynchronous reset, active low.
    input wire logic start, // Begin one lookup at the given point.
    input wire logic [tag_query_pkg::COORD_W-1:0] x, // X of the point to look up.
    input wire logic [tag_query_pkg::COORD_W-1:0] y, // Y of the point to look up.
    input wire logic tag_ack, // Tag store answers, one-cycle pulse.
    input wire logic [tag_query_pkg::TAG_W-1:0] tag_data, // Tag value with tag_ack.
    output logic idle, // No lookup in flight.
    output logic tag_req, // Lookup request level, from a flip-flop.
    output logic [tag_query_pkg::COORD_W-1:0] tag_req_x, // X held with the request.
    output logic [tag_query_pkg::COORD_W-1:0] tag_req_y, // Y held with the request.
    output logic done, // Lookup finished, one-cycle pulse.
    output logic [tag_query_pkg::TAG_W-1:0] tag // Tag of the finished lookup.
);

    // Whole state of the handshake.
    typedef struct packed {
        fetch_state_e state;
        logic req;
        logic [COORD_W-1:0] x;
        logic [COORD_W-1:0] y;
        logic done;
        logic [TAG_W-1:0] tag;
    } fetch_s;

    fetch_s st_reg;
    fetch_s st_next;

    assign idle = (st_reg.state == FETCH_IDLE);
    assign tag_req = st_reg.req;
    assign tag_req_x = st_reg.x;
    assign tag_req_y = st_reg.y;
    assign done = st_reg.done;
    assign tag = st_reg.tag;

    // Holds the request and point steady until the store acknowledges.
    always_comb
    begin
        st_next = st_reg;
        st_next.done = 1'b0;
        unique case (st_reg.state)
            FETCH_IDLE:
            begin
                if (start)
                begin
                    st_next.state = FETCH_WAIT;
                    st_next.req = 1'b1;
                    st_next.x = x;
                    st_next.y = y;
                end
            end
            FETCH_WAIT:
            begin
                // The store answers from the most recently rendered frame.
                if (tag_ack) // see RULE10
                begin
                    st_next.state = FETCH_IDLE;
                    st_next.req = 1'b0;
                    st_next.done = 1'b1;
                    st_next.tag = tag_data;
                end
            end
            default:
            begin
                st_next.state = FETCH_IDLE;
                st_next.req = 1'b0;
            end
        endcase
    end

    // Registers the handshake state.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_reg <= '0;
            st_reg.state <= FETCH_IDLE;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

endmodule

`default_nettype wire

// >>> tag_query_regs_properties.sv
// Concurrent checks on the ports of the tag query register bank.
`default_nettype none

module tag_query_regs_properties
    import tag_query_pkg::*;
(
    input wire logic clk, // Clock.
    input wire logic arst_n, // Reset, active low.
    input wire logic psel, // Select.
    input wire logic penable, // Enable.
    input wire logic pwrite, // Direction.
    input wire logic [31:0] paddr, // Address.
    input wire logic [3:0] pstrb, // Strobes.
    input wire logic pready, // Ready.
    input wire logic [tag_query_pkg::DATA_W-1:0] prdata, // Read data.
    input wire logic pslverr, // Error.
    input wire logic frame_done, // New frame.
    input wire logic tag_ack, // Store answer.
    input wire logic tag_req, // Store request.
    input wire logic [tag_query_pkg::COORD_W-1:0] tag_req_x, // Request X.
    input wire logic [tag_query_pkg::COORD_W-1:0] tag_req_y // Request Y.
);
    // All checks use the rising edge and rest during reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // A completed write of X or Y with both low byte lanes strobed, which must start a lookup.
    logic xy_wr;
    assign xy_wr = pready && pwrite && pstrb[1:0] == 2'b11 && paddr inside {32'h74, 32'h78};

    chk_ready_wait: assert property (
        pready |-> psel && penable && $past(psel && penable && !pready))
        else $error("Ready came without one wait state.");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("Ready stood longer than one cycle.");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("Read data not zero outside a transfer.");
    chk_result_bits: assert property (
        pready && !pwrite && paddr == 32'h7c |-> prdata[31:8] == 24'h0)
        else $error("Result reserved bits not zero.");
    chk_coord_bits: assert property (
        pready && !pwrite && paddr inside {32'h74, 32'h78} |-> prdata[31:11] == 21'h0)
        else $error("Coordinate reserved bits not zero.");
    chk_addr_decode: assert property (
        pready |-> pslverr == !(paddr inside {32'h74, 32'h78, 32'h7c, 32'h80}))
        else $error("Error flag disagrees with the address map.");
    chk_req_hold: assert property (
        tag_req && !tag_ack |=> tag_req && $stable(tag_req_x) && $stable(tag_req_y))
        else $error("Lookup request changed before its answer.");
    chk_req_drop: assert property (tag_req && tag_ack |=> !tag_req)
        else $error("Lookup request stayed after its answer.");
    chk_write_launch: assert property (xy_wr && !tag_req |-> ##[1:3] tag_req)
        else $error("No lookup after a coordinate write.");
    chk_frame_relook: assert property (frame_done && !tag_req |-> ##[1:3] tag_req)
        else $error("No lookup after a new frame.");

    // Main scenarios reached.
    cover property (xy_wr);
    cover property (tag_req && tag_ack);
    cover property (pready && pslverr);
    cover property (frame_done && tag_req);
endmodule

bind tag_lookup_query_regs tag_query_regs_properties i_tag_query_regs_properties (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .frame_done(frame_done), .tag_ack(tag_ack), .tag_req(tag_req),
    .tag_req_x(tag_req_x), .tag_req_y(tag_req_y));

`default_nettype wire

// >>> tb.sv
// Self-checking bench for the tag query register bank.
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import tag_query_pkg::*;

    logic clk = 1'b0; // Bench clock.
    logic arst_n, psel, penable, pwrite, frame_done, pready, pslverr, tag_req, err;
    logic tag_ack = 1'b0; // Store answer strobe, driven only by the store stand-in.
    logic [31:0] paddr, pwdata, prdata, rd, yw;
    logic [3:0] pstrb; // Byte strobes.
    logic [7:0] tag_data = 8'h00, frame_cnt; // Store answer and frame number.
    logic [10:0] tag_req_x, tag_req_y, x, y; // Request point and host point.
    logic [2:0] delay = 3'd0; // Store answer delay.
    logic [31:0] bad [4] = '{32'h70, 32'h75, 32'h84, 32'h1074}; // Unmapped places.
    int errors = 0;
    int checks_done = 0;

    // Clock of 100 ns period.
    always #50 clk = ~clk;

    tag_lookup_query_regs i_tag_lookup_query_regs (
        .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .frame_done(frame_done), .tag_ack(tag_ack), .tag_data(tag_data),
        .tag_req(tag_req), .tag_req_x(tag_req_x), .tag_req_y(tag_req_y));

    // Tag the frame store holds for a point of a frame.
    function automatic logic [7:0] tag_of(input logic [10:0] px, py, input logic [7:0] f);
        return px[7:0] ^ {py[4:0], py[10:8]} ^ f;
    endfunction

    // Frame store stand-in: answers after a random wait; data is noise otherwise.
    always @(posedge clk)
    begin
        if (tag_req && !tag_ack && delay == 3'd0)
        begin
            tag_ack <= 1'b1;
            tag_data <= tag_of(tag_req_x, tag_req_y, frame_cnt);
        end
        else
        begin
            tag_ack <= 1'b0;
            tag_data <= 8'($urandom);
            delay <= tag_req ? delay - 3'd1 : 3'($urandom);
        end
    end

    // Counts a comparison and reports a mismatch.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // One APB transfer; read data and error land in rd and err.
    task automatic apb(input logic wr, input logic [31:0] a, d, input logic [3:0] s);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            errors++;
            tally_and_finish();
        end
    endtask

    // Waits for the lookup to settle, then reads X, Y and the tag back.
    task automatic check_point();
        int n;
        n = 0;
        do
        begin
            apb(1'b0, 32'h80, 32'h0, 4'h0);
            n++;
        end
        while (rd[0] !== 1'b0 && n < 40);
        chk("busy", 32'h0, {31'h0, rd[0]});
        apb(1'b0, 32'h74, 32'h0, 4'h0);
        chk("x", {21'h0, x}, rd);
        apb(1'b0, 32'h78, 32'h0, 4'h0);
        chk("y", {21'h0, y}, rd);
        apb(1'b0, 32'h7c, 32'h0, 4'h0);
        chk("tag", {24'h0, tag_of(x, y, frame_cnt)}, rd);
    endtask

    // Main sequence.
    initial
    begin
        {arst_n, psel, penable, pwrite, frame_done} = '0;
        {paddr, pwdata, pstrb} = '0;
        frame_cnt = 8'h3c;
        void'($urandom(85747));
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b0, 32'h74 + 32'(4 * i), 32'h0, 4'h0);
            chk("reset value", 32'h0, rd);
        end
        for (int i = 0; i < 10; i++)
        begin
            x = (i == 0) ? 11'h7ff : 11'($urandom);
            y = (i == 1) ? 11'h7ff : (i == 2) ? 11'h000 : 11'($urandom);
            yw = {21'h0, y};
            apb(1'b1, 32'h74, {21'h0, x}, 4'hf);
            apb(1'b1, 32'h78, yw, 4'hf);
            check_point();
        end
        // Read-only result and a partial-strobe write leave everything as it was.
        apb(1'b1, 32'h7c, 32'h0000_00a5, 4'hf);
        apb(1'b1, 32'h74, 32'h0000_0123, 4'h1);
        check_point();
        foreach (bad[i])
        begin
            apb(1'(i), bad[i], 32'h0000_07ff, 4'hf);
            chk("unmapped error", 32'h1, {31'h0, err});
            chk("unmapped data", 32'h0, rd);
        end
        // A new frame during a lookup forces a fresh answer.
        x = 11'($urandom);
        apb(1'b1, 32'h74, {21'h0, x}, 4'hf);
        frame_cnt <= frame_cnt + 8'h11;
        frame_done <= 1'b1;
        @(posedge clk);
        frame_done <= 1'b0;
        // The point written just before is being looked up now; a second frame arrives.
        @(posedge clk);
        chk("lookup launched", 32'h1, {31'h0, tag_req});
        frame_cnt <= frame_cnt + 8'h11;
        frame_done <= 1'b1;
        @(posedge clk);
        frame_done <= 1'b0;
        check_point();
        tally_and_finish();
    end
endmodule

`default_nettype wire
